// >>> rmg_regs.sv
// regulator mode, linear regulator, boost and pin 0 control register bank
`timescale 1ns/1ps
// Functional notes
// - startup load reloads every buck mode field; system reset value is 0xA.
// - an enabled buck takes auto pulse-skip for normal and standby.
// - memory-hold and user-off bits default 0, cleared only by off-reset.
// - switcher PLL enable bit 22 resets to 1, multiplier bit 23 to 0.
// - USB supply enable bit 3 resets to 1, forced to 1 on invalid bus supply.
// - both pass-select bits follow strap bit 4: 0 external, 1 internal.
// - a set standby-control bit lets the standby input switch that regulator.
// - direction 1 drives the pin at bit 2 level; direction 0 is input.
// - bit 1 reports the debounced pin level.
// - debounce field 5-4 selects none, 10, 20 or 30 ms.
// - interrupt field 7-6 selects none, falling, rising or both edges.
// - pull enable bit 11 defaults 1, pull select 13-12 defaults 0x3.
// - time-of-day and day registers reset by clock-domain power-on reset only.
module rmg_regs #(
   parameter logic [23:0] DEBOUNCE_STEP_CYCLES = rmg_pkg::PIN_DEBOUNCE_SELECT_STEP_CYCLES
) (
   // clock and resets
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_off_nrst,
   input wire logic i_global_nrst,
   input wire logic i_clock_domain_por_nrst,
   // register port from the serial control interface
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [5:0] i_addr,
   input wire logic [23:0] i_wdata,
   output logic [23:0] o_rdata,
   output logic o_rd_valid,
   // startup sequencer and system status
   input wire logic i_startup_load,
   input wire logic [5:0] i_buck_enabled,
   input wire logic [4:0] i_power_up_mode_strap,
   input wire logic i_vbus_invalid,
   input wire logic i_standby,
   // regulator controls
   output logic [4:0] o_ldo_active,
   output logic o_usb_supply_enable,
   output logic o_switcher_pll_enable,
   output logic o_switcher_pll_multiplier,
   // low-voltage pin 0
   input wire logic i_pin0_in,
   output logic o_pin0_out,
   output logic o_pin0_oe_n,
   output logic o_pin0_event
);
   rmg_pkg::rmg_word_t reg_q [rmg_pkg::NUM_REGS];
   rmg_pkg::rmg_word_t reg_d [rmg_pkg::NUM_REGS];
   logic [23:0] rdata_q;
   logic rd_valid_q;
   logic [4:0] ldo_active_q;
   logic [4:0] ldo_active_d;
   logic pin_out_q;
   logic pin_oe_n_q;
   logic pin_event_q;

   rmg_pin_if pin_bus ();

   // offset to storage slot
   function automatic logic [3:0] slot_of(input logic [5:0] addr);
      case (addr)
         rmg_pkg::OFS_BUCK12_MODE: slot_of = {1'b1, rmg_pkg::IDX_BUCK12};
         rmg_pkg::OFS_BUCK345_MODE: slot_of = {1'b1, rmg_pkg::IDX_BUCK345};
         rmg_pkg::OFS_LDO_SETTING: slot_of = {1'b1, rmg_pkg::IDX_LDO_SET};
         rmg_pkg::OFS_BOOST_CTRL: slot_of = {1'b1, rmg_pkg::IDX_BOOST};
         rmg_pkg::OFS_LDO_ENABLE: slot_of = {1'b1, rmg_pkg::IDX_LDO_EN};
         rmg_pkg::OFS_PIN0_CTRL: slot_of = {1'b1, rmg_pkg::IDX_PIN0};
         rmg_pkg::OFS_TIME_OF_DAY: slot_of = {1'b1, rmg_pkg::IDX_TOD};
         rmg_pkg::OFS_DAY_COUNT: slot_of = {1'b1, rmg_pkg::IDX_DAY};
         default: slot_of = 4'h0;
      endcase
   endfunction : slot_of

   function automatic logic [3:0] startup_mode(input logic enabled);
      startup_mode = enabled ? rmg_pkg::MODE_AUTO_PULSE_SKIP : rmg_pkg::MODE_OFF;
   endfunction : startup_mode

   // bits driven by hardware every cycle must not drop to zero while a reset is held
   function automatic rmg_pkg::rmg_word_t kept_bits(input int i);
      kept_bits = rmg_pkg::OFF_MASK[i];
      if (i == int'(rmg_pkg::IDX_LDO_EN)) begin
         kept_bits[rmg_pkg::POS_LDO2_PASS] = 1'b1;
         kept_bits[rmg_pkg::POS_USB_LDO_PASS] = 1'b1;
      end
      if (i == int'(rmg_pkg::IDX_PIN0)) begin
         kept_bits[rmg_pkg::POS_PIN_DIN] = 1'b1;
      end
   endfunction : kept_bits

   wire [3:0] addr_slot = slot_of(i_addr);
   wire addr_hit = addr_slot[3];
   wire [2:0] addr_idx = addr_slot[2:0];
   wire strap_pass = i_power_up_mode_strap[rmg_pkg::STRAP_PASS_BIT];
   wire [23:0] pin_reg = reg_q[rmg_pkg::IDX_PIN0];
   wire [23:0] ldo_reg = reg_q[rmg_pkg::IDX_LDO_EN];
   wire [23:0] rd_word = addr_hit ? reg_q[addr_idx] : 24'h000000;

   // next value of every slot
   always_comb begin
      for (int i = 0; i < rmg_pkg::NUM_REGS; i++) begin
         reg_d[i] = reg_q[i];
         if (i_wr && addr_hit && addr_idx == 3'(i)) begin
            reg_d[i] = (reg_q[i] & ~rmg_pkg::WR_MASK[i]) | (i_wdata & rmg_pkg::WR_MASK[i]);
         end
      end
      // sequencer load overrides a same-cycle write to the mode fields
      if (i_startup_load) begin
         reg_d[rmg_pkg::IDX_BUCK12][rmg_pkg::POS_B1A_MODE +: 4] = startup_mode(i_buck_enabled[0]);
         reg_d[rmg_pkg::IDX_BUCK12][rmg_pkg::POS_B2_MODE +: 4] = startup_mode(i_buck_enabled[1]);
         reg_d[rmg_pkg::IDX_BUCK345][rmg_pkg::POS_B3_MODE +: 4] = startup_mode(i_buck_enabled[2]);
         reg_d[rmg_pkg::IDX_BUCK345][rmg_pkg::POS_B4A_MODE +: 4] = startup_mode(i_buck_enabled[3]);
         reg_d[rmg_pkg::IDX_BUCK345][rmg_pkg::POS_B4B_MODE +: 4] = startup_mode(i_buck_enabled[4]);
         reg_d[rmg_pkg::IDX_BUCK345][rmg_pkg::POS_B5_MODE +: 4] = startup_mode(i_buck_enabled[5]);
      end
      // invalid bus supply wins over a write of 0
      if (i_vbus_invalid) begin
         reg_d[rmg_pkg::IDX_LDO_EN][rmg_pkg::POS_USB_EN] = 1'b1;
      end
      reg_d[rmg_pkg::IDX_LDO_EN][rmg_pkg::POS_LDO2_PASS] = strap_pass;
      reg_d[rmg_pkg::IDX_LDO_EN][rmg_pkg::POS_USB_LDO_PASS] = strap_pass;
      reg_d[rmg_pkg::IDX_PIN0][rmg_pkg::POS_PIN_DIN] = pin_bus.level;
      if (!i_off_nrst) begin
         reg_d[rmg_pkg::IDX_BUCK12] = reg_d[rmg_pkg::IDX_BUCK12] & ~rmg_pkg::OFF_MASK[0];
         reg_d[rmg_pkg::IDX_BUCK345] = reg_d[rmg_pkg::IDX_BUCK345] & ~rmg_pkg::OFF_MASK[1];
      end
   end

   // standby input only gates regulators whose standby-control bit is set
   always_comb begin
      for (int k = 0; k < rmg_pkg::NUM_LDO; k++) begin
         ldo_active_d[k] = ldo_reg[rmg_pkg::LDO_EN_POS[k]] &
                           ~(ldo_reg[rmg_pkg::LDO_STBY_POS[k]] & i_standby);
      end
   end

   // one process owns the whole array; clock-domain slots ignore system and global reset
   always_ff @(posedge i_clock) begin
      for (int i = 0; i < rmg_pkg::NUM_REGS; i++) begin
         if (i >= int'(rmg_pkg::IDX_TOD)) begin
            reg_q[i] <= i_clock_domain_por_nrst ? reg_d[i] : rmg_pkg::RST_VAL[i];
         end else if (!i_nrst || !i_global_nrst) begin
            reg_q[i] <= (reg_d[i] & kept_bits(i)) | rmg_pkg::RST_VAL[i];
         end else begin
            reg_q[i] <= reg_d[i];
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         rdata_q <= 24'h000000;
         rd_valid_q <= 1'b0;
         ldo_active_q <= 5'h00;
         pin_out_q <= 1'b0;
         pin_oe_n_q <= 1'b1;
         pin_event_q <= 1'b0;
      end else begin
         rdata_q <= i_rd ? rd_word : rdata_q;
         rd_valid_q <= i_rd;
         ldo_active_q <= ldo_active_d;
         pin_out_q <= pin_reg[rmg_pkg::POS_PIN_DOUT];
         pin_oe_n_q <= ~pin_reg[rmg_pkg::POS_PIN_DIR];
         pin_event_q <= pin_bus.evt;
      end
   end

   // pin filter hookup
   assign pin_bus.raw = i_pin0_in;
   assign pin_bus.pin_debounce_select_sel = pin_reg[rmg_pkg::POS_PIN_PIN_DEBOUNCE_SELECT +: 2];
   assign pin_bus.irq_sel = rmg_pkg::rmg_irq_e'(pin_reg[rmg_pkg::POS_PIN_IRQ +: 2]);

   rmg_pin_filter #(
      .STEP_CYCLES(DEBOUNCE_STEP_CYCLES)
   ) u_pin_filter (
      .i_clock(i_clock),
      .i_nrst(i_nrst),
      .pin(pin_bus.filt)
   );

   assign o_rdata = rdata_q;
   assign o_rd_valid = rd_valid_q;
   assign o_ldo_active = ldo_active_q;
   assign o_usb_supply_enable = ldo_reg[rmg_pkg::POS_USB_EN];
   assign o_switcher_pll_enable = reg_q[rmg_pkg::IDX_BUCK12][rmg_pkg::POS_PLL_EN];
   assign o_switcher_pll_multiplier = reg_q[rmg_pkg::IDX_BUCK12][rmg_pkg::POS_PLL_MULT];
   assign o_pin0_out = pin_out_q;
   assign o_pin0_oe_n = pin_oe_n_q;
   assign o_pin0_event = pin_event_q;

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_clock_domain_por_nrst);

   wire [23:0] b12 = reg_q[rmg_pkg::IDX_BUCK12];

   sequence s_sys_reset;
      !i_nrst && i_off_nrst && !i_startup_load;
   endsequence

   chk_mode_reset_value: assert property (
      s_sys_reset |=> b12[3:0] == rmg_pkg::MODE_RESET && b12[17:14] == rmg_pkg::MODE_RESET)
      else $error("buck mode not 0xA after system reset");
   chk_startup_aps: assert property (
      (i_startup_load && i_buck_enabled[1]) |=> b12[17:14] == rmg_pkg::MODE_AUTO_PULSE_SKIP)
      else $error("enabled buck not in auto pulse-skip after load");
   chk_hold_survives: assert property (
      s_sys_reset |=> (b12 & rmg_pkg::OFF_MASK[0]) == ($past(b12) & rmg_pkg::OFF_MASK[0]))
      else $error("hold or user-off bit changed by system reset");
   chk_off_clears: assert property (
      !i_off_nrst |=> (reg_q[rmg_pkg::IDX_BUCK345] & rmg_pkg::OFF_MASK[1]) == 24'h000000)
      else $error("off-reset left a hold or user-off bit set");
   chk_fixed_defaults: assert property (
      s_sys_reset |=> b12[7:6] == 2'b01 && b12[21:20] == 2'b01 &&
                      o_switcher_pll_enable && !o_switcher_pll_multiplier)
      else $error("speed or switcher pll default wrong");
   chk_boost_default: assert property (
      s_sys_reset |=> reg_q[rmg_pkg::IDX_BOOST][6:2] == 5'h12)
      else $error("boost mode defaults wrong");
   chk_usb_forced: assert property (
      i_vbus_invalid |=> o_usb_supply_enable)
      else $error("invalid bus supply did not force usb enable");
   chk_pass_strap: assert property (
      1'b1 |=> ldo_reg[rmg_pkg::POS_LDO2_PASS] == $past(strap_pass) &&
               ldo_reg[rmg_pkg::POS_USB_LDO_PASS] == $past(strap_pass))
      else $error("pass select does not follow strap");
   chk_standby_off: assert property (
      (i_nrst && i_standby && ldo_reg[1]) |=> !o_ldo_active[0])
      else $error("standby-controlled regulator stayed on");
   chk_pin_drive: assert property (
      (i_nrst && pin_reg[0]) |=> !o_pin0_oe_n && o_pin0_out == $past(pin_reg[2]))
      else $error("output pin not driven from data bit");
   chk_din_level: assert property (
      i_nrst |=> pin_reg[rmg_pkg::POS_PIN_DIN] == $past(pin_bus.level))
      else $error("input bit does not show pin level");
   chk_pull_default: assert property (
      s_sys_reset |=> pin_reg[11] && pin_reg[13:12] == 2'b11)
      else $error("pull defaults wrong");
   chk_unused_zero: assert property (
      b12[13:8] == 6'h00 && reg_q[rmg_pkg::IDX_BOOST][23:8] == 16'h0000 &&
      pin_reg[23:16] == 8'h00)
      else $error("unused bit set");
   chk_tod_keeps: assert property (
      (!i_global_nrst && !(i_wr && addr_hit && addr_idx == rmg_pkg::IDX_TOD))
      |=> reg_q[rmg_pkg::IDX_TOD] == $past(reg_q[rmg_pkg::IDX_TOD]))
      else $error("time of day disturbed by global reset");
endmodule : rmg_regs

// >>> rmg_pkg.sv
// constants for the regulator mode and low-voltage pin register bank
package rmg_pkg;
   // register offsets as printed (register index on the control port)
   localparam logic [5:0] OFS_TIME_OF_DAY = 6'h14;
   localparam logic [5:0] OFS_DAY_COUNT = 6'h16;
   localparam logic [5:0] OFS_BUCK12_MODE = 6'h1c;
   localparam logic [5:0] OFS_BUCK345_MODE = 6'h1d;
   localparam logic [5:0] OFS_LDO_SETTING = 6'h1e;
   localparam logic [5:0] OFS_BOOST_CTRL = 6'h1f;
   localparam logic [5:0] OFS_LDO_ENABLE = 6'h20;
   localparam logic [5:0] OFS_PIN0_CTRL = 6'h21;

   localparam int NUM_REGS = 8;
   typedef logic [23:0] rmg_word_t;
   typedef logic [2:0] rmg_idx_t;

   // storage slots
   localparam rmg_idx_t IDX_BUCK12 = 3'h0;
   localparam rmg_idx_t IDX_BUCK345 = 3'h1;
   localparam rmg_idx_t IDX_LDO_SET = 3'h2;
   localparam rmg_idx_t IDX_BOOST = 3'h3;
   localparam rmg_idx_t IDX_LDO_EN = 3'h4;
   localparam rmg_idx_t IDX_PIN0 = 3'h5;
   localparam rmg_idx_t IDX_TOD = 3'h6;
   localparam rmg_idx_t IDX_DAY = 3'h7;

   // writable bits per slot; other bits read zero except the strap-driven pass-select bits and the pin level bit
   localparam rmg_word_t WR_MASK [NUM_REGS] = '{
      24'hffc0ff, 24'hffffff, 24'h001ff7, 24'h0000ff,
      24'h1df47f, 24'h00fffd, 24'hffffff, 24'h007fff};
   // system reset values
   localparam rmg_word_t RST_VAL [NUM_REGS] = '{
      24'h52804a, 24'h28a28a, 24'h000000, 24'h000048,
      24'h000008, 24'h003808, 24'h000000, 24'h000000};
   // bits kept through system reset, cleared only by the off-reset
   localparam rmg_word_t OFF_MASK [NUM_REGS] = '{
      24'h0c0030, 24'hc30c30, 24'h000000, 24'h000000,
      24'h000000, 24'h000000, 24'h000000, 24'h000000};

   // buck operating-mode field positions (lsb)
   localparam int MODE_W = 4;
   localparam int POS_B1A_MODE = 0;
   localparam int POS_B2_MODE = 14;
   localparam int POS_B3_MODE = 0;
   localparam int POS_B4A_MODE = 6;
   localparam int POS_B4B_MODE = 12;
   localparam int POS_B5_MODE = 18;
   localparam logic [3:0] MODE_AUTO_PULSE_SKIP = 4'ha;
   localparam logic [3:0] MODE_OFF = 4'h0;
   localparam logic [3:0] MODE_RESET = 4'ha;

   // other buck12 / boost fields
   localparam int POS_B1A_HOLD = 4;
   localparam int POS_B1A_USER_OFF = 5;
   localparam int POS_B1_SPEED = 6;
   localparam int POS_B2_SPEED = 20;
   localparam int POS_PLL_EN = 22;
   localparam int POS_PLL_MULT = 23;
   localparam int POS_BOOST_NORMAL = 2;
   localparam int POS_BOOST_STBY = 5;

   // linear regulator enable / standby / pass-select bits
   localparam int NUM_LDO = 5;
   localparam int LDO_EN_POS [NUM_LDO] = '{0, 4, 12, 15, 18};
   localparam int LDO_STBY_POS [NUM_LDO] = '{1, 5, 13, 16, 19};
   localparam int POS_USB_EN = 3;
   localparam int POS_LDO2_PASS = 11;
   localparam int POS_USB_LDO_PASS = 17;
   localparam int STRAP_PASS_BIT = 4;

   // pin control fields
   localparam int POS_PIN_DIR = 0;
   localparam int POS_PIN_DIN = 1;
   localparam int POS_PIN_DOUT = 2;
   localparam int POS_PIN_PIN_DEBOUNCE_SELECT = 4;
   localparam int POS_PIN_IRQ = 6;
   localparam int POS_PIN_PULL_EN = 11;
   localparam int POS_PIN_PULL_SEL = 12;

   // debounce timing
   localparam int PIN_DEBOUNCE_SELECT_STEP_MS = 10;
   localparam int CLOCK_HZ = 50_000_000;
   localparam logic [23:0] PIN_DEBOUNCE_SELECT_STEP_CYCLES = 24'(PIN_DEBOUNCE_SELECT_STEP_MS * (CLOCK_HZ / 1000));

   typedef enum logic [1:0] {
      RMG_IRQ_NONE = 2'b00,
      RMG_IRQ_FALL = 2'b01,
      RMG_IRQ_RISE = 2'b10,
      RMG_IRQ_BOTH = 2'b11
   } rmg_irq_e;
endpackage : rmg_pkg

// >>> rmg_pin_if.sv
// carrier between the register bank and the pin input filter
`timescale 1ns/1ps
interface rmg_pin_if;
   logic raw;
   logic [1:0] pin_debounce_select_sel;
   rmg_pkg::rmg_irq_e irq_sel;
   logic level;
   logic evt;
   modport ctrl (output raw, output pin_debounce_select_sel, output irq_sel, input level, input evt);
   modport filt (input raw, input pin_debounce_select_sel, input irq_sel, output level, output evt);
endinterface : rmg_pin_if

// >>> rmg_pin_filter.sv
// debounce and edge detection for low-voltage pin 0
`timescale 1ns/1ps
module rmg_pin_filter #(
   parameter logic [23:0] STEP_CYCLES = rmg_pkg::PIN_DEBOUNCE_SELECT_STEP_CYCLES
) (
   input wire logic i_clock,
   input wire logic i_nrst,
   rmg_pin_if.filt pin
);
   logic level_q;
   logic level_d;
   logic evt_q;
   logic evt_d;
   logic [23:0] cnt_q;
   logic [23:0] cnt_d;
   logic [23:0] limit;
   logic differs;
   logic done;

   // multiply by 0, 1, 2 or 3 with adds only
   function automatic logic [23:0] pin_debounce_select_limit(input logic [1:0] sel, input logic [23:0] step);
      logic [23:0] acc;
      acc = 24'h000000;
      if (sel[0]) acc = step;
      if (sel[1]) acc = 24'(acc + {step[22:0], 1'b0});
      return acc;
   endfunction : pin_debounce_select_limit

   assign limit = pin_debounce_select_limit(pin.pin_debounce_select_sel, STEP_CYCLES);
   assign differs = pin.raw != level_q;
   // count restarts whenever the input bounces back
   assign done = (pin.pin_debounce_select_sel == 2'b00) || (cnt_q + 24'h000001 >= limit);
   assign cnt_d = (differs && !done) ? 24'(cnt_q + 24'h000001) : 24'h000000;
   assign level_d = (differs && done) ? pin.raw : level_q;
   assign evt_d = (level_d != level_q) &&
                  ((pin.irq_sel == rmg_pkg::RMG_IRQ_BOTH) ||
                   (pin.irq_sel == rmg_pkg::RMG_IRQ_RISE && level_d) ||
                   (pin.irq_sel == rmg_pkg::RMG_IRQ_FALL && !level_d));

   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         level_q <= 1'b0;
         evt_q <= 1'b0;
         cnt_q <= 24'h000000;
      end else begin
         level_q <= level_d;
         evt_q <= evt_d;
         cnt_q <= cnt_d;
      end
   end

   assign pin.level = level_q;
   assign pin.evt = evt_q;

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_nrst);

   chk_no_debounce_pass: assert property (
      (pin.pin_debounce_select_sel == 2'b00 && differs) |=> level_q == $past(pin.raw))
      else $error("undebounced input did not pass in one cycle");
   chk_rise_event: assert property (
      (pin.irq_sel == rmg_pkg::RMG_IRQ_RISE && !level_q && level_d) |=> evt_q)
      else $error("rising edge raised no event");
   chk_no_event_off: assert property (
      (pin.irq_sel == rmg_pkg::RMG_IRQ_NONE) |=> !evt_q)
      else $error("event raised while disabled");
   chk_short_glitch: assert property (
      (pin.pin_debounce_select_sel != 2'b00 && !differs) ##1 (differs && cnt_q == 24'h000000)
      |-> ##1 level_q == $past(level_q, 2))
      else $error("debounced level moved on the first differing sample");
endmodule : rmg_pin_filter

// >>> rmg_host.sv
// host model issuing accesses on the register port of the bank
`timescale 1ns/1ps
module rmg_host (
   // clock
   input wire logic i_clock,
   // answer from the bank
   input wire logic [23:0] i_rdata,
   input wire logic i_rd_valid,
   // request to the bank
   output logic o_wr,
   output logic o_rd,
   output logic [5:0] o_addr,
   output logic [23:0] o_wdata
);
   initial begin
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = 6'h00;
      o_wdata = 24'h000000;
   end

   // one-cycle strobe; released data is inverted so nothing stale looks valid
   task automatic write_reg(input logic [5:0] a, input logic [23:0] d);
      @(posedge i_clock);
      o_wr <= 1'b1;
      o_addr <= a;
      o_wdata <= d;
      @(posedge i_clock);
      o_wr <= 1'b0;
      o_wdata <= ~d;
   endtask : write_reg

   // answer sampled at the edge after it was launched, bounded wait
   task automatic read_reg(input logic [5:0] a, output logic [23:0] d, output bit ok);
      int n;
      ok = 1'b0;
      d = 24'h000000;
      @(posedge i_clock);
      o_rd <= 1'b1;
      o_addr <= a;
      @(posedge i_clock);
      o_rd <= 1'b0;
      for (n = 0; n < 4 && !ok; n++) begin
         @(posedge i_clock);
         if (i_rd_valid === 1'b1) begin
            d = i_rdata;
            ok = 1'b1;
         end
      end
   endtask : read_reg
endmodule : rmg_host

// >>> rmg_regs_bench.sv
// self-checking bench for the regulator mode and pin 0 register bank
`timescale 1ns/1ps
module rmg_regs_bench;
   localparam int STEP = 8;
   localparam logic [5:0] ADDRS [10] = '{6'h1c, 6'h1d, 6'h1e, 6'h1f, 6'h20, 6'h21,
      6'h14, 6'h16, 6'h00, 6'h3f};
   localparam logic [23:0] RST [6] = '{24'h52804a, 24'h28a28a, 24'h000000,
      24'h000048, 24'h000008, 24'h003808};
   localparam int BSLOT [6] = '{0, 0, 1, 1, 1, 1};
   localparam int BPOS [6] = '{0, 14, 0, 6, 12, 18};
   logic i_clock = 1'b0;
   logic i_nrst = 1'b0;
   logic i_off_nrst = 1'b0;
   logic i_global_nrst = 1'b0;
   logic i_clock_domain_por_nrst = 1'b0;
   logic i_startup_load = 1'b0;
   logic [5:0] i_buck_enabled = 6'h00;
   logic [4:0] i_power_up_mode_strap = 5'h00;
   logic i_vbus_invalid = 1'b0;
   logic i_standby = 1'b0;
   logic i_pin0_in = 1'b0;
   logic wr, rd, rd_valid, pin_out, pin_oe_n, pin_evt, usb_en, pll_en, pll_mult;
   logic [5:0] addr;
   logic [23:0] wdata, rdata;
   logic [4:0] ldo_act;
   logic [23:0] mdl [8];
   logic pin_lvl = 1'b0;
   int fail_count = 0;
   int compares = 0;
   int seed = 32'haab1da08;
   int i, j, s, m;

   always #10 i_clock = ~i_clock;

   rmg_host u_host (.i_clock(i_clock), .i_rdata(rdata), .i_rd_valid(rd_valid), .o_wr(wr),
      .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
   rmg_regs #(.DEBOUNCE_STEP_CYCLES(24'h000008)) u_dut (.i_clock(i_clock), .i_nrst(i_nrst),
      .i_off_nrst(i_off_nrst), .i_global_nrst(i_global_nrst),
      .i_clock_domain_por_nrst(i_clock_domain_por_nrst), .i_wr(wr), .i_rd(rd), .i_addr(addr),
      .i_wdata(wdata), .o_rdata(rdata), .o_rd_valid(rd_valid), .i_startup_load(i_startup_load),
      .i_buck_enabled(i_buck_enabled), .i_power_up_mode_strap(i_power_up_mode_strap),
      .i_vbus_invalid(i_vbus_invalid), .i_standby(i_standby), .o_ldo_active(ldo_act),
      .o_usb_supply_enable(usb_en), .o_switcher_pll_enable(pll_en),
      .o_switcher_pll_multiplier(pll_mult), .i_pin0_in(i_pin0_in), .o_pin0_out(pin_out),
      .o_pin0_oe_n(pin_oe_n), .o_pin0_event(pin_evt));

   task automatic final_report();
      $display("mismatches %0d comparisons %0d", fail_count, compares);
      if (fail_count == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : final_report

   task automatic chk_word(input logic [23:0] got, input logic [23:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t word got %h expected %h", $time, got, exp);
      end
   endtask : chk_word

   task automatic chk_num(input int got, input int exp);
      compares++;
      if (got != exp) begin
         fail_count++;
         $display("[FAIL] %0t count got %0d expected %0d", $time, got, exp);
      end
   endtask : chk_num

   function automatic int slot(input logic [5:0] a);
      if (a >= 6'h1c && a <= 6'h21) return int'(a) - 28;
      if (a == 6'h14) return 6;
      if (a == 6'h16) return 7;
      return -1;
   endfunction : slot

   function automatic logic [23:0] exp_of(input logic [5:0] a);
      logic [23:0] e;
      e = (slot(a) < 0) ? 24'h000000 : mdl[slot(a)];
      if (slot(a) == 4) begin
         e[11] = i_power_up_mode_strap[4];
         e[17] = i_power_up_mode_strap[4];
      end
      if (slot(a) == 5) e[1] = pin_lvl;
      return e;
   endfunction : exp_of

   // reset codes: 3 system, 2 off, 1 global, 0 clock-domain power-on
   task automatic rst_pulse(input logic [3:0] c, input int n);
      int k;
      @(posedge i_clock);
      {i_nrst, i_off_nrst, i_global_nrst, i_clock_domain_por_nrst} <= ~c;
      repeat (n) @(posedge i_clock);
      {i_nrst, i_off_nrst, i_global_nrst, i_clock_domain_por_nrst} <= 4'hf;
      for (k = 0; k < 6; k++) begin
         if (c[3] | c[1]) mdl[k] = (mdl[k] & rmg_pkg::OFF_MASK[k]) | RST[k];
         if (c[2]) mdl[k] = mdl[k] & ~rmg_pkg::OFF_MASK[k];
      end
      if (c[0]) begin
         mdl[6] = 24'h000000;
         mdl[7] = 24'h000000;
      end
   endtask : rst_pulse

   task automatic wr_reg(input logic [5:0] a, input logic [23:0] d);
      u_host.write_reg(a, d);
      if (slot(a) >= 0) mdl[slot(a)] = d & rmg_pkg::WR_MASK[slot(a)];
      if (slot(a) == 4 && i_vbus_invalid) mdl[4][3] = 1'b1;
   endtask : wr_reg

   task automatic rd_chk(input logic [5:0] a);
      logic [23:0] d;
      bit ok;
      u_host.read_reg(a, d, ok);
      if (!ok) begin
         fail_count++;
         $display("[FAIL] %0t read answer missing", $time);
         final_report();
      end else chk_word(d, exp_of(a));
   endtask : rd_chk

   task automatic chk_outs();
      int k;
      chk_word(24'(pll_en), 24'(mdl[0][22]));
      chk_word(24'(pll_mult), 24'(mdl[0][23]));
      chk_word(24'(usb_en), 24'(mdl[4][3]));
      chk_word(24'(pin_oe_n), 24'(!mdl[5][0]));
      chk_word(24'(pin_out), 24'(mdl[5][2]));
      for (k = 0; k < 5; k++) chk_word(24'(ldo_act[k]), 24'(mdl[4][rmg_pkg::LDO_EN_POS[k]] &
         !(mdl[4][rmg_pkg::LDO_STBY_POS[k]] & i_standby)));
   endtask : chk_outs

   // drive a new pin level, count edge events and the delay to the first
   task automatic pin_edge(input logic v, input int sel, input logic [1:0] mode, input int hold);
      int c, t, hits;
      t = 0;
      hits = 0;
      @(posedge i_clock);
      i_pin0_in <= v;
      for (c = 1; c <= 40; c++) begin
         @(posedge i_clock);
         if (c == hold) i_pin0_in <= ~v;
         #1;
         if (pin_evt === 1'b1) begin
            hits++;
            if (t == 0) t = c;
         end
      end
      if (hold > 0) chk_num(hits, 0);
      else begin
         chk_num(hits, v ? mode[1] : mode[0]);
         if (v ? mode[1] : mode[0]) chk_num(t, ((sel == 0) ? 1 : sel * STEP) + 1);
         pin_lvl = v;
      end
      rd_chk(6'h21);
   endtask : pin_edge

   initial begin
      rst_pulse(4'hf, 20);
      for (i = 0; i < 10; i++) rd_chk(ADDRS[i]);
      chk_outs();
      for (j = 0; j < 4; j++) begin
         i_power_up_mode_strap <= 5'($random(seed));
         i_standby <= 1'($random(seed));
         for (i = 0; i < 10; i++) wr_reg(ADDRS[i], (j == 0) ? 24'hffffff : 24'($random(seed)));
         for (i = 0; i < 10; i++) rd_chk(ADDRS[i]);
         chk_outs();
      end
      i_vbus_invalid <= 1'b1;
      repeat (2) @(posedge i_clock);
      mdl[4][3] = 1'b1;
      wr_reg(6'h20, 24'h000000);
      rd_chk(6'h20);
      chk_outs();
      i_vbus_invalid <= 1'b0;
      wr_reg(6'h20, 24'h000000);
      rd_chk(6'h20);
      for (j = 0; j < 3; j++) begin
         i_buck_enabled <= (j == 0) ? 6'h3f : 6'($random(seed));
         @(posedge i_clock);
         i_startup_load <= 1'b1;
         @(posedge i_clock);
         i_startup_load <= 1'b0;
         for (i = 0; i < 6; i++) mdl[BSLOT[i]][BPOS[i] +: 4] = i_buck_enabled[i] ? 4'ha : 4'h0;
         rd_chk(6'h1c);
         rd_chk(6'h1d);
      end
      wr_reg(6'h1c, 24'hffffff);
      wr_reg(6'h1d, 24'hffffff);
      rst_pulse(4'h8, 2);
      for (i = 0; i < 6; i++) rd_chk(ADDRS[i]);
      rst_pulse(4'h4, 2);
      for (i = 0; i < 2; i++) rd_chk(ADDRS[i]);
      wr_reg(6'h14, 24'($random(seed)));
      wr_reg(6'h16, 24'($random(seed)));
      wr_reg(6'h1f, 24'h000000);
      rst_pulse(4'h2, 2);
      for (i = 0; i < 8; i++) rd_chk(ADDRS[i]);
      rst_pulse(4'h1, 2);
      for (i = 6; i < 8; i++) rd_chk(ADDRS[i]);
      // every debounce length against every edge selection
      for (s = 0; s < 4; s++) begin
         for (m = 0; m < 4; m++) begin
            wr_reg(6'h21, 24'h003808 | 24'(s << 4) | 24'(m << 6));
            pin_edge(1'b1, s, 2'(m), 0);
            pin_edge(1'b0, s, 2'(m), 0);
         end
      end
      // a short glitch under debounce must leave the level alone
      wr_reg(6'h21, 24'h0038d8);
      pin_edge(1'b1, 1, 2'b11, STEP / 2);
      final_report();
   end
endmodule : rmg_regs_bench
